// file: core/fault_status_pkg.sv
// Constants shared by the half-bridge fault status bank, its assertion monitor and its testbench
package fault_status_pkg;

    // Address byte layout: operation bit, five-bit code, tail bit, fixed bit
    localparam int ADDR_OP_POS = 7;
    localparam int ADDR_CODE_MSB = 6;
    localparam int ADDR_CODE_LSB = 2;
    localparam int ADDR_TAIL_POS = 1;
    localparam logic OP_READ = 1'h0;

    // Five-bit register codes placed between operation bit and tail bits
    localparam logic [4:0] CODE_OC_9_UP = 5'h1E;
    localparam logic [4:0] CODE_OL_1_4 = 5'h01;
    localparam logic [4:0] CODE_OL_5_8 = 5'h11;
    localparam logic [4:0] CODE_OL_9_UP = 5'h09;

    // Register width, reset value and reserved upper nibble
    localparam int REG_W = 8;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] RESERVED_UPPER_MASK = 8'hF0;

    // First bridge number held by each register
    localparam int FIRST_BRIDGE_1_4 = 1;
    localparam int FIRST_BRIDGE_5_8 = 5;
    localparam int FIRST_BRIDGE_9_UP = 9;

    // Field positions inside a register holding bridges b..b+3
    localparam int POS_LOW_FIRST = 0;
    localparam int POS_HIGH_FIRST = 1;
    localparam int POS_LOW_SECOND = 2;
    localparam int POS_HIGH_SECOND = 3;

    // Documented bridge count of the full variant
    localparam int BRIDGES_FULL = 10;

    // Reset synchroniser depth
    localparam int RST_SYNC_STAGES = 2;

endpackage

// file: core/fault_flag_latch.sv
// Sticky fault flag latch with clear on read, where a new fault wins
`timescale 1ns/1ps
module fault_flag_latch #(
    parameter int WIDTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_keep_mask,
    input wire logic i_clear,
    output logic [WIDTH-1:0] o_flags
);

    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // Clear drops the old flags, a set arriving in the same cycle survives
    assign flags_nxt = ((i_clear ? '0 : flags_r) | i_set) & i_keep_mask;

    // Flags hold until read, starting from no fault
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign o_flags = flags_r;

endmodule

// file: core/half_bridge_fault_status_bank.sv
// Read-to-clear overcurrent and open-load status bank for ten half-bridges
//
// Function
// - High-side overcurrent on bridge 9 or 10 latches D1/D3 and switches it off.
// - Low-side overcurrent on bridge 9 or 10 latches D0/D2 and switches it off.
// - Upper four bits of the bridge 9-up overcurrent register always read zero.
// - Bits of absent bridges on smaller variants always read zero.
// - Bridges 1-4 open load: high side bit 2n-1, low side bit 2n-2.
// - Bridges 5-8 open load: high odd bit, low even bit, bridge 5 lowest.
// - Bridges 9-10 open load in low nibble; upper nibble reads zero.
// - All flags are zero after reset.
// - Code 111 10 in the address byte selects the bridge 9-up overcurrent register.
// - Codes 000 01, 100 01, 010 01 select the three open-load registers.
// - Global load error is the OR of all fault flags, clears with them.
`timescale 1ns/1ps
module half_bridge_fault_status_bank #(
    parameter int NUM_BRIDGES = fault_status_pkg::BRIDGES_FULL
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Register access from the serial frame decoder
    input wire logic i_access_strobe,
    input wire logic [7:0] i_addr_byte,
    output logic [7:0] o_read_data,
    output logic o_read_valid,
    output logic o_addr_hit,
    // Analog fault detectors, level, one bit per bridge (open load bit 0 = bridge 1, overcurrent bit 0 = bridge 9)
    input wire logic [9:0] i_open_load_high,
    input wire logic [9:0] i_open_load_low,
    input wire logic [1:0] i_overcurrent_high,
    input wire logic [1:0] i_overcurrent_low,
    // Switch on requests for bridges 9 and 10 (bit 0 = bridge 9)
    input wire logic [1:0] i_switch_high_cmd,
    input wire logic [1:0] i_switch_low_cmd,
    output logic [1:0] o_switch_high_on,
    output logic [1:0] o_switch_low_on,
    // Fault flags held by the other status registers of the device
    input wire logic i_other_load_error,
    output logic o_global_load_error_flag
);

    // Reset release through two flip-flops
    logic [fault_status_pkg::RST_SYNC_STAGES-1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_r <= '0;
        end else begin
            rst_sync_r <= {rst_sync_r[fault_status_pkg::RST_SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[fault_status_pkg::RST_SYNC_STAGES-1];

    // Interleave four high/low pairs: high in odd bits, low in even bits
    function automatic logic [7:0] pack_pairs(input logic [3:0] high, input logic [3:0] low);
        logic [7:0] packed_bits;
        packed_bits = fault_status_pkg::FLAGS_RESET;
        for (int k = 0; k < 4; k++) begin
            packed_bits[2*k+1] = high[k];
            packed_bits[2*k] = low[k];
        end
        return packed_bits;
    endfunction

    // Mask of bits whose bridges exist on this variant
    function automatic logic [7:0] bridge_mask(input int first_bridge);
        logic [7:0] mask;
        mask = fault_status_pkg::FLAGS_RESET;
        for (int k = 0; k < 4; k++) begin
            if (first_bridge + k <= NUM_BRIDGES) begin
                mask[2*k+1] = 1'b1;
                mask[2*k] = 1'b1;
            end
        end
        return mask;
    endfunction

    // Masks per register, the upper nibble of the 9-up registers always dropped
    localparam logic [7:0] MASK_1_4 = bridge_mask(fault_status_pkg::FIRST_BRIDGE_1_4);
    localparam logic [7:0] MASK_5_8 = bridge_mask(fault_status_pkg::FIRST_BRIDGE_5_8);
    localparam logic [7:0] MASK_9_UP = bridge_mask(fault_status_pkg::FIRST_BRIDGE_9_UP)
        & ~fault_status_pkg::RESERVED_UPPER_MASK;

    // Address byte fields
    wire logic op_bit;
    wire logic [4:0] addr_code;
    assign op_bit = i_addr_byte[fault_status_pkg::ADDR_OP_POS];
    assign addr_code = i_addr_byte[fault_status_pkg::ADDR_CODE_MSB:fault_status_pkg::ADDR_CODE_LSB];

    // Register selects
    wire logic sel_oc_9_up;
    wire logic sel_ol_1_4;
    wire logic sel_ol_5_8;
    wire logic sel_ol_9_up;
    wire logic is_read;

    assign sel_oc_9_up = (addr_code == fault_status_pkg::CODE_OC_9_UP);
    assign sel_ol_1_4 = (addr_code == fault_status_pkg::CODE_OL_1_4);
    assign sel_ol_5_8 = (addr_code == fault_status_pkg::CODE_OL_5_8);
    assign sel_ol_9_up = (addr_code == fault_status_pkg::CODE_OL_9_UP);

    assign is_read = i_access_strobe && (op_bit == fault_status_pkg::OP_READ);

    // Clear strobes, only on a read of the selected register
    wire logic clr_oc_9_up;
    wire logic clr_ol_1_4;
    wire logic clr_ol_5_8;
    wire logic clr_ol_9_up;

    assign clr_oc_9_up = is_read && sel_oc_9_up;
    assign clr_ol_1_4 = is_read && sel_ol_1_4;
    assign clr_ol_5_8 = is_read && sel_ol_5_8;
    assign clr_ol_9_up = is_read && sel_ol_9_up;

    // Detector inputs arranged into register bit order
    wire logic [7:0] set_oc_9_up;
    wire logic [7:0] set_ol_1_4;
    wire logic [7:0] set_ol_5_8;
    wire logic [7:0] set_ol_9_up;

    // high-side overcurrent into D1 and D3
    // low-side overcurrent into D0 and D2
    assign set_oc_9_up = pack_pairs({2'h0, i_overcurrent_high}, {2'h0, i_overcurrent_low});
    // bridges 1-4, bit 2n-1 high and 2n-2 low
    assign set_ol_1_4 = pack_pairs(i_open_load_high[3:0], i_open_load_low[3:0]);
    // bridges 5-8, bridge 5 at D1/D0
    assign set_ol_5_8 = pack_pairs(i_open_load_high[7:4], i_open_load_low[7:4]);
    // bridges 9-10 in the low nibble
    assign set_ol_9_up = pack_pairs({2'h0, i_open_load_high[9:8]}, {2'h0, i_open_load_low[9:8]});

    // Latched flags of the four registers
    logic [7:0] flags_oc_9_up;
    logic [7:0] flags_ol_1_4;
    logic [7:0] flags_ol_5_8;
    logic [7:0] flags_ol_9_up;

    // reserved nibble forced to zero by the keep mask
    fault_flag_latch #(
        .WIDTH(fault_status_pkg::REG_W)
    ) u_latch_oc_9_up (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_set(set_oc_9_up),
        .i_keep_mask(MASK_9_UP),
        .i_clear(clr_oc_9_up),
        .o_flags(flags_oc_9_up)
    );

    // absent bridges masked off in every register
    fault_flag_latch #(
        .WIDTH(fault_status_pkg::REG_W)
    ) u_latch_ol_1_4 (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_set(set_ol_1_4),
        .i_keep_mask(MASK_1_4),
        .i_clear(clr_ol_1_4),
        .o_flags(flags_ol_1_4)
    );

    fault_flag_latch #(
        .WIDTH(fault_status_pkg::REG_W)
    ) u_latch_ol_5_8 (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_set(set_ol_5_8),
        .i_keep_mask(MASK_5_8),
        .i_clear(clr_ol_5_8),
        .o_flags(flags_ol_5_8)
    );

    // upper nibble of the 9-up open-load register held at zero
    fault_flag_latch #(
        .WIDTH(fault_status_pkg::REG_W)
    ) u_latch_ol_9_up (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_set(set_ol_9_up),
        .i_keep_mask(MASK_9_UP),
        .i_clear(clr_ol_9_up),
        .o_flags(flags_ol_9_up)
    );

    // Read multiplexer; unknown codes return zero
    wire logic [7:0] read_mux;
    wire logic hit;

    assign hit = sel_oc_9_up | sel_ol_1_4 | sel_ol_5_8 | sel_ol_9_up;
    assign read_mux = sel_oc_9_up ? flags_oc_9_up :
                      sel_ol_1_4 ? flags_ol_1_4 :
                      sel_ol_5_8 ? flags_ol_5_8 :
                      sel_ol_9_up ? flags_ol_9_up :
                      fault_status_pkg::FLAGS_RESET;

    // Read data, valid and hit registers
    logic [7:0] read_data_r;
    logic read_valid_r;
    logic addr_hit_r;

    // data captured before the clear takes effect
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data_r <= fault_status_pkg::FLAGS_RESET;
            read_valid_r <= 1'b0;
            addr_hit_r <= 1'b0;
        end else begin
            read_valid_r <= is_read;
            if (is_read) begin
                read_data_r <= read_mux;
                addr_hit_r <= hit;
            end
        end
    end

    assign o_read_data = read_data_r;
    assign o_read_valid = read_valid_r;
    assign o_addr_hit = addr_hit_r;

    // Overcurrent shutdown terms for bridges 9 and 10
    wire logic [1:0] oc_high_latched;
    wire logic [1:0] oc_low_latched;
    wire logic [1:0] present_9_up;
    wire logic [1:0] high_off;
    wire logic [1:0] low_off;

    assign oc_high_latched = {flags_oc_9_up[fault_status_pkg::POS_HIGH_SECOND],
                              flags_oc_9_up[fault_status_pkg::POS_HIGH_FIRST]};
    assign oc_low_latched = {flags_oc_9_up[fault_status_pkg::POS_LOW_SECOND],
                             flags_oc_9_up[fault_status_pkg::POS_LOW_FIRST]};
    assign present_9_up = {MASK_9_UP[fault_status_pkg::POS_HIGH_SECOND],
                           MASK_9_UP[fault_status_pkg::POS_HIGH_FIRST]};

    // high side held off while detected or latched
    assign high_off = i_overcurrent_high | oc_high_latched | ~present_9_up;
    // low side held off while detected or latched
    assign low_off = i_overcurrent_low | oc_low_latched | ~present_9_up;

    // Switch drive registers
    logic [1:0] switch_high_on_r;
    logic [1:0] switch_low_on_r;

    // open-load flags take no part in the switch gating
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            switch_high_on_r <= 2'h0;
            switch_low_on_r <= 2'h0;
        end else begin
            switch_high_on_r <= i_switch_high_cmd & ~high_off;
            switch_low_on_r <= i_switch_low_cmd & ~low_off;
        end
    end

    assign o_switch_high_on = switch_high_on_r;
    assign o_switch_low_on = switch_low_on_r;

    // Global load error, combinational so it drops as soon as flags clear
    wire logic any_local_fault;

    assign any_local_fault = (|flags_oc_9_up) | (|flags_ol_1_4) |
                             (|flags_ol_5_8) | (|flags_ol_9_up);
    assign o_global_load_error_flag = any_local_fault | i_other_load_error;

endmodule

// file: verification/fault_status_monitor.sv
// Assertion checker for the half-bridge fault status bank ports
`timescale 1ns/1ps
module fault_status_monitor (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_access_strobe,
    input wire logic [7:0] i_addr_byte,
    input wire logic [7:0] o_read_data,
    input wire logic o_read_valid,
    input wire logic o_addr_hit,
    input wire logic [1:0] i_overcurrent_high,
    input wire logic [1:0] i_overcurrent_low,
    input wire logic [1:0] i_switch_high_cmd,
    input wire logic [1:0] o_switch_high_on,
    input wire logic [1:0] o_switch_low_on,
    input wire logic o_global_load_error_flag
);
    logic [1:0] up_r;
    wire ready = up_r == 2'h3;
    wire [4:0] code = i_addr_byte[6:2];
    wire known = code == fault_status_pkg::CODE_OC_9_UP || code == fault_status_pkg::CODE_OL_1_4
        || code == fault_status_pkg::CODE_OL_5_8 || code == fault_status_pkg::CODE_OL_9_UP;
    // Counts edges after release so checks start once accesses are legal
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) up_r <= 2'h0;
        else if (!ready) up_r <= up_r + 2'h1;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!ready);
    sequence read_req;
        i_access_strobe && !i_addr_byte[7];
    endsequence
    a_read_valid_pulse: assert property (read_req |=> o_read_valid)
        else $error("read not answered");
    a_write_no_valid: assert property (!(i_access_strobe && !i_addr_byte[7]) |=> !o_read_valid)
        else $error("valid without read");
    a_oc_reserved_zero: assert property (read_req ##0 code == fault_status_pkg::CODE_OC_9_UP
        |=> o_read_data[7:4] == 4'h0) else $error("oc upper nibble set");
    a_ol_reserved_zero: assert property (read_req ##0 code == fault_status_pkg::CODE_OL_9_UP
        |=> o_read_data[7:4] == 4'h0) else $error("ol upper nibble set");
    a_unknown_code_zero: assert property (read_req ##0 !known |=> !o_addr_hit && o_read_data == 8'h00)
        else $error("unknown code answered");
    a_oc_high_off: assert property (i_overcurrent_high[0] |=> !o_switch_high_on[0])
        else $error("high switch left on");
    a_oc_low_off: assert property (i_overcurrent_low[1] |=> !o_switch_low_on[1])
        else $error("low switch left on");
    a_oc_global_set: assert property ((i_overcurrent_high | i_overcurrent_low) != 2'h0
        |=> o_global_load_error_flag) else $error("global flag missing");
    a_switch_stays_on: assert property (o_switch_high_on[0] && i_switch_high_cmd[0]
        && !i_overcurrent_high[0] |=> o_switch_high_on[0]) else $error("switch dropped");
endmodule
bind half_bridge_fault_status_bank fault_status_monitor mon_u (.i_core_clk, .i_resetn,
    .i_access_strobe, .i_addr_byte, .o_read_data, .o_read_valid, .o_addr_hit, .i_overcurrent_high,
    .i_overcurrent_low, .i_switch_high_cmd, .o_switch_high_on, .o_switch_low_on,
    .o_global_load_error_flag);

// file: verification/host_reader_model.sv
// Host controller model issuing register accesses to the status bank
`timescale 1ns/1ps
module host_reader_model (
    input wire logic i_core_clk,
    input wire logic i_read_valid,
    input wire logic [7:0] i_read_data,
    output logic o_access_strobe,
    output logic [7:0] o_addr_byte
);
    // Idle bus
    initial begin
        o_access_strobe = 1'b0;
        o_addr_byte = 8'hFF;
    end
    // One access held across one edge, answer taken just after it
    task automatic access(input logic op, input logic [4:0] code, input int gap,
            output logic valid, output logic [7:0] data);
        o_addr_byte = {op, code, 2'h1};
        o_access_strobe = 1'b1;
        @(posedge i_core_clk);
        #1;
        valid = i_read_valid;
        data = i_read_data;
        o_access_strobe = 1'b0;
        o_addr_byte = ~o_addr_byte;
        repeat (gap + 1) @(posedge i_core_clk);
        #1;
    endtask
endmodule

// file: verification/tb_half_bridge_fault_status_bank.sv
// Self-checking bench for the half-bridge fault status bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    checks_done++; \
    if ((got) !== (ex)) begin \
        $display("BAD %s exp %h got %h", nm, ex, got); \
        err_total++; \
    end
module tb_half_bridge_fault_status_bank;
    logic clk, rst_n, strobe, valid, hit, glob, other, v;
    logic [7:0] addr, rdata, d;
    logic [9:0] olh, oll;
    logic [1:0] och, ocl, cmdh, cmdl, onh, onl;
    int err_total, checks_done, cyc;
    half_bridge_fault_status_bank dut_u (.i_core_clk(clk), .i_resetn(rst_n),
        .i_access_strobe(strobe), .i_addr_byte(addr), .o_read_data(rdata), .o_read_valid(valid),
        .o_addr_hit(hit), .i_open_load_high(olh), .i_open_load_low(oll),
        .i_overcurrent_high(och), .i_overcurrent_low(ocl), .i_switch_high_cmd(cmdh),
        .i_switch_low_cmd(cmdl), .o_switch_high_on(onh), .o_switch_low_on(onl),
        .i_other_load_error(other), .o_global_load_error_flag(glob));
    host_reader_model host_u (.i_core_clk(clk), .i_read_valid(valid), .i_read_data(rdata),
        .o_access_strobe(strobe), .o_addr_byte(addr));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("Counts: checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Expected open-load register for bridges first..first+3
    function automatic logic [7:0] ol_exp(int first, logic [9:0] h, logic [9:0] l);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (first + k <= 10) begin
                r[2*k+1] = h[first+k-1];
                r[2*k] = l[first+k-1];
            end
        end
        return r;
    endfunction
    // One-cycle open-load pulse, then a refused write followed by a read for each of the three registers
    task automatic ol_case(input logic [9:0] h, input logic [9:0] l);
        logic [4:0] codes[3];
        int first[3];
        codes = '{fault_status_pkg::CODE_OL_1_4, fault_status_pkg::CODE_OL_5_8,
            fault_status_pkg::CODE_OL_9_UP};
        first = '{1, 5, 9};
        olh = h;
        oll = l;
        @(posedge clk);
        #1;
        olh = 10'h000;
        oll = 10'h000;
        `CHK("global", |{h, l}, glob)
        `CHK("ol_sw", 4'hF, {onh, onl})
        for (int i = 0; i < 3; i++) begin
            host_u.access(1'b1, codes[i], 0, v, d);
            `CHK("write", 1'b0, v)
            host_u.access(1'b0, codes[i], $urandom_range(2), v, d);
            `CHK("ol_reg", ol_exp(first[i], h, l), d)
            `CHK("ol_hit", 1'b1, hit)
        end
        `CHK("cleared", 1'b0, glob)
    endtask
    // Overcurrent pulse: switch off and latched until the register is read
    task automatic oc_case(input int i);
        logic [1:0] b;
        logic [3:0] e;
        b = 2'h1 << (i % 2);
        e = (i < 2) ? {~b, 2'h3} : {2'h3, ~b};
        if (i < 2) och = b;
        else ocl = b;
        @(posedge clk);
        #1;
        och = 2'h0;
        ocl = 2'h0;
        `CHK("sw_off", e, {onh, onl})
        repeat (3) @(posedge clk);
        #1;
        `CHK("sw_held", e, {onh, onl})
        host_u.access(1'b0, fault_status_pkg::CODE_OC_9_UP, 0, v, d);
        `CHK("oc_reg", 8'h1 << (2 * (i % 2) + (i < 2)), d)
        @(posedge clk);
        #1;
        `CHK("sw_on", 4'hF, {onh, onl})
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h1185));
        {rst_n, other, och, ocl, olh, oll} = '0;
        cmdh = 2'h3;
        cmdl = 2'h3;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        host_u.access(1'b0, fault_status_pkg::CODE_OC_9_UP, 0, v, d);
        `CHK("oc_rst", 8'h00, d)
        ol_case(10'h000, 10'h000);
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            ol_case(i % 2 ? 10'h1 << (i / 2) : 10'h0, i % 2 ? 10'h0 : 10'h1 << (i / 2));
        end
        $display("test one-hot open load done");
        for (int i = 0; i < 16; i++) begin
            ol_case(10'($urandom), 10'($urandom));
        end
        $display("test random open load done");
        for (int i = 0; i < 4; i++) begin
            oc_case(i);
        end
        $display("test overcurrent done");
        host_u.access(1'b0, 5'h00, 0, v, d);
        `CHK("unknown", 9'h000, {hit, d})
        other = 1'b1;
        #1;
        `CHK("other", 1'b1, glob)
        other = 1'b0;
        $display("test decode done");
        end_sim();
    end
endmodule
